// File: dosc_pkg.sv
// package: register map, field layout and reset values of the output-state control
package dosc_pkg;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_DAC = 4'h4;
   localparam logic [3:0] ADDR_SWCTL = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   localparam int CTRL_FBSEL_BIT = 1;
   localparam int CTRL_HIZ_BIT = 2;
   localparam int CTRL_CLAMP_BIT = 3;
   localparam int CTRL_LIN_LSB = 6;
   localparam int SW_RESET_BIT = 2;
   localparam logic RST_HIZ = 1'b1;
   localparam logic RST_CLAMP = 1'b1;
   localparam logic RST_FBSEL = 1'b0;
   localparam logic [3:0] RST_LIN = 4'h0;
   localparam logic [17:0] RST_DAC = 18'h00000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {OUT_NORMAL, OUT_HIZ, OUT_CLAMP} dosc_mode_t;
   typedef struct packed {
      logic hiz;
      logic clamp;
      logic fbsel;
      logic [3:0] lin;
   } dosc_ctrl_t;
   localparam dosc_ctrl_t RST_CTRL = '{hiz: RST_HIZ, clamp: RST_CLAMP, fbsel: RST_FBSEL,
                                       lin: RST_LIN};
   typedef struct packed {
      logic awvalid;
      logic [3:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [3:0] araddr;
      logic rready;
   } dosc_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } dosc_axi_rsp_t;
   function automatic dosc_mode_t dosc_decode(input logic hiz, input logic clamp);
      if (clamp) begin
         return OUT_CLAMP;
      end else if (hiz) begin
         return OUT_HIZ;
      end
      return OUT_NORMAL;
   endfunction
endpackage

// File: dosc_outstage.sv
// output stage: decodes control bits into registered analog switch controls
`timescale 1ns/100ps
module dosc_outstage
   import dosc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic ce,
   input wire logic rst_n,
   input wire logic soft_rst,
   // control
   input dosc_pkg::dosc_ctrl_t ctrl,
   // switch controls
   output dosc_pkg::dosc_mode_t mode,
   output logic core_hiz_ctl,
   output logic out_gnd_clamp_ctl,
   output logic ref_connect
);
   typedef struct packed {
      dosc_mode_t mode;
      logic hiz;
      logic clamp;
      logic refc;
   } dosc_os_state_t;
   dosc_os_state_t st_ff, nxt_st;
   localparam dosc_os_state_t RST_OS = '{mode: OUT_CLAMP, hiz: RST_HIZ | RST_CLAMP, clamp: RST_CLAMP,
                                         refc: 1'b0};

   always_comb begin
      nxt_st = st_ff;
      nxt_st.mode = dosc_decode(ctrl.hiz, ctrl.clamp);
      nxt_st.clamp = ctrl.clamp;
      nxt_st.hiz = ctrl.hiz | ctrl.clamp;
      nxt_st.refc = ~(ctrl.hiz | ctrl.clamp);
      if (soft_rst) begin
         nxt_st = RST_OS;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= RST_OS;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign mode = st_ff.mode;
   assign core_hiz_ctl = st_ff.hiz;
   assign out_gnd_clamp_ctl = st_ff.clamp;
   assign ref_connect = st_ff.refc;

   chk_clamp_wins: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && !soft_rst && ctrl.clamp) |=> (mode == OUT_CLAMP && !ref_connect))
      else $error("clamp bit did not force clamp");
endmodule // dosc_outstage

// File: dosc_top.sv
// top: AXI4-Lite control register and output-state control of the converter
//
// Behaviour
// - Reset returns all registers to defaults.
// - Power-on: core high-impedance, output ground-clamped.
// - Power-on state holds until control written.
// - Normal mode with default code gives negative reference.
// - Clamp wins; else hiz; else normal.
// - Compensation resets to 0000.
// - Feedback select 1: parallel internal resistors.
// - Feedback select 0: gain-of-two arrangement.
// - High-impedance bit resets to one.
// - Software reset restores power-on state.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module dosc_top
   import dosc_pkg::*;
#(
   parameter int DAC_W = 18
) (
   // clock, enable, reset
   input wire logic CLK,
   input wire logic CE,
   input wire logic RESET_N,
   // axi4-lite slave
   input dosc_pkg::dosc_axi_req_t AXI_REQ,
   output dosc_pkg::dosc_axi_rsp_t AXI_RSP,
   // analog control
   output logic CORE_HIZ_CTL,
   output logic OUT_GND_CLAMP_CTL,
   output logic REF_CONNECT,
   output logic FEEDBACK_RES_SEL,
   output logic [3:0] LIN_COMP,
   output logic [DAC_W-1:0] DAC_CODE
);
   typedef struct packed {
      dosc_ctrl_t ctrl;
      logic [DAC_W-1:0] dac;
      logic soft_rst;
      logic aw_got;
      logic [3:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      dosc_axi_rsp_t rsp;
      logic fbsel;
      logic [3:0] lin;
      logic [DAC_W-1:0] dac_o;
   } dosc_state_t;

   dosc_state_t st_ff, nxt_st;
   dosc_mode_t mode;
   logic hiz_o, clamp_o, refc_o;
   logic do_write;
   logic [31:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_word = 32'h00000000;
      case (AXI_REQ.araddr)
         ADDR_CTRL: begin
            rd_word[CTRL_FBSEL_BIT] = st_ff.ctrl.fbsel;
            rd_word[CTRL_HIZ_BIT] = st_ff.ctrl.hiz;
            rd_word[CTRL_CLAMP_BIT] = st_ff.ctrl.clamp;
            rd_word[CTRL_LIN_LSB +: 4] = st_ff.ctrl.lin;
         end
         ADDR_DAC: begin
            rd_word[DAC_W-1:0] = st_ff.dac;
         end
         ADDR_STATUS: begin
            rd_word[1:0] = mode;
            rd_word[2] = refc_o;
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   assign do_write = st_ff.aw_got && st_ff.w_got && !st_ff.rsp.bvalid;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.soft_rst = 1'b0;
      nxt_st.rsp.awready = 1'b0;
      nxt_st.rsp.wready = 1'b0;
      nxt_st.rsp.arready = 1'b0;
      // accept address and data in either order
      if (AXI_REQ.awvalid && !st_ff.aw_got && !st_ff.rsp.awready) begin
         nxt_st.rsp.awready = 1'b1;
      end
      if (st_ff.rsp.awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = AXI_REQ.awaddr;
      end
      if (AXI_REQ.wvalid && !st_ff.w_got && !st_ff.rsp.wready) begin
         nxt_st.rsp.wready = 1'b1;
      end
      if (st_ff.rsp.wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = AXI_REQ.wdata;
         nxt_st.wstrb = AXI_REQ.wstrb;
      end
      if (do_write) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.rsp.bvalid = 1'b1;
         nxt_st.rsp.bresp = RESP_OKAY;
         case (st_ff.awaddr)
            ADDR_CTRL: begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.ctrl.fbsel = st_ff.wdata[CTRL_FBSEL_BIT];
                  nxt_st.ctrl.hiz = st_ff.wdata[CTRL_HIZ_BIT];
                  nxt_st.ctrl.clamp = st_ff.wdata[CTRL_CLAMP_BIT];
                  nxt_st.ctrl.lin[1:0] = st_ff.wdata[CTRL_LIN_LSB +: 2];
               end
               if (st_ff.wstrb[1]) begin
                  nxt_st.ctrl.lin[3:2] = st_ff.wdata[CTRL_LIN_LSB+2 +: 2];
               end
            end
            ADDR_DAC: begin
               nxt_st.dac = st_ff.wdata[DAC_W-1:0];
            end
            ADDR_SWCTL: begin
               nxt_st.soft_rst = st_ff.wstrb[0] & st_ff.wdata[SW_RESET_BIT];
            end
            ADDR_STATUS: begin
               nxt_st.rsp.bresp = RESP_SLVERR;
            end
            default: begin
               nxt_st.rsp.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_ff.rsp.bvalid && AXI_REQ.bready) begin
         nxt_st.rsp.bvalid = 1'b0;
      end
      // read channel
      if (AXI_REQ.arvalid && !st_ff.rsp.arready && !st_ff.rsp.rvalid) begin
         nxt_st.rsp.arready = 1'b1;
         nxt_st.rsp.rvalid = 1'b1;
         nxt_st.rsp.rdata = rd_word;
         nxt_st.rsp.rresp = (AXI_REQ.araddr == ADDR_SWCTL) ? RESP_SLVERR : RESP_OKAY;
      end
      if (st_ff.rsp.rvalid && AXI_REQ.rready) begin
         nxt_st.rsp.rvalid = 1'b0;
      end
      // outputs follow completed writes
      nxt_st.fbsel = st_ff.ctrl.fbsel;
      nxt_st.lin = st_ff.ctrl.lin;
      nxt_st.dac_o = st_ff.dac;
      if (st_ff.soft_rst) begin
         nxt_st.ctrl = RST_CTRL;
         nxt_st.dac = RST_DAC;
         nxt_st.fbsel = RST_FBSEL;
         nxt_st.lin = RST_LIN;
         nxt_st.dac_o = RST_DAC;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         st_ff <= '0;
         st_ff.ctrl <= RST_CTRL;
         st_ff.dac <= RST_DAC;
      end else if (CE) begin
         st_ff <= nxt_st;
      end
   end

   dosc_outstage dosc_outstage_i (
      .clk(CLK),
      .ce(CE),
      .rst_n(RESET_N),
      .soft_rst(st_ff.soft_rst),
      .ctrl(st_ff.ctrl),
      .mode(mode),
      .core_hiz_ctl(hiz_o),
      .out_gnd_clamp_ctl(clamp_o),
      .ref_connect(refc_o)
   );

   assign AXI_RSP = st_ff.rsp;
   assign CORE_HIZ_CTL = hiz_o;
   assign OUT_GND_CLAMP_CTL = clamp_o;
   assign REF_CONNECT = refc_o;
   assign FEEDBACK_RES_SEL = st_ff.fbsel;
   assign LIN_COMP = st_ff.lin;
   assign DAC_CODE = st_ff.dac_o;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_ctrl_write;
      do_write && st_ff.awaddr == ADDR_CTRL && st_ff.wstrb[0] && CE;
   endsequence
   sequence s_outputs_follow;
      CE [*2];
   endsequence

   chk_reset_state: assert property (@(posedge CLK)
      $rose(RESET_N) |-> (CORE_HIZ_CTL && OUT_GND_CLAMP_CTL && !REF_CONNECT))
      else $error("output not clamped after reset");
   chk_lin_reset: assert property (@(posedge CLK)
      $rose(RESET_N) |-> (LIN_COMP == RST_LIN && st_ff.ctrl.lin == RST_LIN))
      else $error("compensation not zero after reset");
   chk_hiz_reset: assert property (@(posedge CLK)
      $rose(RESET_N) |-> st_ff.ctrl.hiz)
      else $error("hiz bit not set after reset");
   chk_hold_state: assert property (@(posedge CLK) disable iff (!RESET_N)
      (RESET_N && !do_write && !st_ff.soft_rst) |=> $stable(st_ff.ctrl))
      else $error("control changed without a write");
   chk_fbsel_write: assert property (@(posedge CLK) disable iff (!RESET_N)
      s_ctrl_write ##0 (st_ff.wdata[CTRL_FBSEL_BIT] && !st_ff.soft_rst) ##1 s_outputs_follow
      |-> FEEDBACK_RES_SEL)
      else $error("feedback select not applied");
   chk_normal_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
      s_ctrl_write ##0 (!st_ff.wdata[CTRL_HIZ_BIT] && !st_ff.wdata[CTRL_CLAMP_BIT]
      && !st_ff.soft_rst) ##1 s_outputs_follow |-> (mode == OUT_NORMAL && REF_CONNECT))
      else $error("normal mode not entered");
   chk_soft_reset: assert property (@(posedge CLK) disable iff (!RESET_N)
      (st_ff.soft_rst && CE) ##1 CE |=> (CORE_HIZ_CTL && OUT_GND_CLAMP_CTL
      && LIN_COMP == RST_LIN && DAC_CODE == RST_DAC))
      else $error("software reset incomplete");
   chk_hiz_only: assert property (@(posedge CLK) disable iff (!RESET_N)
      (RESET_N && CE && st_ff.ctrl.hiz && !st_ff.ctrl.clamp && !st_ff.soft_rst) |=>
      (mode == OUT_HIZ && !OUT_GND_CLAMP_CTL))
      else $error("hiz decode wrong");
endmodule // dosc_top

// File: dosc_host.sv
// host model: axi4-lite master for the control registers
`timescale 1ns/100ps
module dosc_host
   import dosc_pkg::*;
(
   // clock
   input wire logic clk,
   // bus
   input dosc_pkg::dosc_axi_rsp_t rsp,
   output dosc_pkg::dosc_axi_req_t req
);
   int lag = 0;
   initial req = '0;
   ////////////////////////////////////////////////////////////////////////////////
   // write, bready raised after lag cycles
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      req.bready <= (lag == 0);
      do begin
         @(posedge clk);
         n++;
         if (rsp.awready) begin
            req.awvalid <= 1'b0;
            req.awaddr <= ~a;
         end
         if (rsp.wready) begin
            req.wvalid <= 1'b0;
            req.wdata <= ~d;
         end
         if (n >= lag) req.bready <= 1'b1;
      end while (!(rsp.bvalid && req.bready));
      r = rsp.bresp;
      req.bready <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // read
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (rsp.arready) begin
            req.arvalid <= 1'b0;
            req.araddr <= ~a;
         end
      end while (!rsp.rvalid);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask
endmodule // dosc_host

// File: tb_top.sv
// testbench: output-state control driven over its register bus
`timescale 1ns/100ps
module tb_top;
   import dosc_pkg::*;
   logic clk;
   logic ce;
   logic reset_n;
   dosc_axi_req_t req;
   dosc_axi_rsp_t rsp;
   logic hiz;
   logic clamp;
   logic refc;
   logic fb;
   logic [3:0] lin;
   logic [17:0] code;
   logic [31:0] d;
   logic [1:0] r;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   dosc_host dosc_host_i (.clk(clk), .rsp(rsp), .req(req));
   dosc_top #(.DAC_W(18)) dosc_top_i (.CLK(clk), .CE(ce), .RESET_N(reset_n), .AXI_REQ(req),
      .AXI_RSP(rsp), .CORE_HIZ_CTL(hiz), .OUT_GND_CLAMP_CTL(clamp), .REF_CONNECT(refc),
      .FEEDBACK_RES_SEL(fb), .LIN_COMP(lin), .DAC_CODE(code));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (bad_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic outs(input logic h, input logic c, input logic f, input logic [3:0] l);
      chk("core_hiz_ctl", 32'(hiz), 32'(h | c));
      chk("out_gnd_clamp_ctl", 32'(clamp), 32'(c));
      chk("ref_connect", 32'(refc), 32'(!(h | c)));
      chk("feedback_res_sel", 32'(fb), 32'(f));
      chk("lin_comp", 32'(lin), 32'(l));
   endtask
   task automatic wrc(input logic [3:0] a, input logic [31:0] v, input logic [1:0] re);
      dosc_host_i.wr(a, v, r);
      chk("bresp", 32'(r), 32'(re));
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] re);
      dosc_host_i.rd(a, d, r);
      chk("rdata", d, e);
      chk("rresp", 32'(r), 32'(re));
   endtask
   task automatic defaults();
      outs(1'b1, 1'b1, 1'b0, 4'h0);
      chk("dac_code", 32'(code), 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ce = 1'b1;
      reset_n = 1'b0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      defaults();
      rdc(ADDR_CTRL, 32'h0000000C, RESP_OKAY);
      rdc(ADDR_STATUS, 32'h2, RESP_OKAY);
      wrc(ADDR_CTRL, 32'h0000030C, RESP_OKAY);
      outs(1'b1, 1'b1, 1'b0, 4'hC);
      for (int i = 0; i < 4; i++) begin
         wrc(ADDR_CTRL, {22'h0, i[1] ? 4'hC : 4'h0, 2'b00, i[1], i[0], i[0] ^ i[1], 1'b0},
            RESP_OKAY);
         if (i == 0) chk("dac_code", 32'(code), 32'h0);
         outs(i[0], i[1], i[0] ^ i[1], i[1] ? 4'hC : 4'h0);
         rdc(ADDR_STATUS, i[1] ? 32'h2 : (i[0] ? 32'h1 : 32'h4), RESP_OKAY);
      end
      // back-to-back writes, second one right after the first response
      dosc_host_i.wr(ADDR_DAC, 32'h00000001, r);
      chk("bresp", 32'(r), 32'(RESP_OKAY));
      dosc_host_i.wr(ADDR_DAC, 32'h00015555, r);
      chk("bresp", 32'(r), 32'(RESP_OKAY));
      rdc(ADDR_DAC, 32'h00015555, RESP_OKAY);
      wrc(ADDR_DAC, 32'h0003FFFF, RESP_OKAY);
      chk("dac_code", 32'(code), 32'h3FFFF);
      // late bready: response must stand until taken
      dosc_host_i.lag = 6;
      wrc(ADDR_CTRL, 32'h00000302, RESP_OKAY);
      dosc_host_i.lag = 0;
      outs(1'b0, 1'b0, 1'b1, 4'hC);
      wrc(ADDR_STATUS, 32'h0000000C, RESP_SLVERR);
      outs(1'b0, 1'b0, 1'b1, 4'hC);
      rdc(ADDR_SWCTL, 32'h0, RESP_SLVERR);
      wrc(ADDR_SWCTL, 32'h4, RESP_OKAY);
      defaults();
      rdc(ADDR_CTRL, 32'h0000000C, RESP_OKAY);
      wrc(ADDR_CTRL, 32'h00000302, RESP_OKAY);
      @(posedge clk);
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      defaults();
      stop_test();
   end
endmodule // tb_top
